// File: bench/adcrc_regs_monitor.sv
// adcrc_regs_monitor: bus handshake, reset and result placement checks.
// assumes it is bound to adcrc_regs and sees only that module's ports.
`timescale 1ns/1ns
module adcrc_regs_monitor
  import adcrc_pkg::*;
#(
  parameter int BUS_W = 32
) (
  input wire logic                   ref_clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   por_rst_i,
  input wire logic [4:0]             avs_address_i,
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic [BUS_W-1:0]       avs_writedata_i,
  input wire logic [BUS_W/8-1:0]     avs_byteenable_i,
  input wire logic [BUS_W-1:0]       avs_readdata_o,
  input wire logic                   avs_waitrequest_o,
  input wire logic                   conv_done_i,
  input wire logic [9:0]             conversion_result_i,
  input wire logic                   justify_select_o,
  input wire logic                   previous_source_select_o,
  input wire logic [2:0]             shift_count_o,
  input wire adcrc_pkg::adcrc_mode_t filter_mode_o,
  input wire logic                   lower_threshold_o,
  input wire logic                   upper_threshold_o
);
  logic       ctrl_commit;
  logic [9:0] res_reg, res_next;
  logic [7:0] cw_reg, cw_next;

  // ----------
  // result and control shadows
  // ----------
  assign ctrl_commit = avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h0a
                       && avs_byteenable_i[0];
  always_comb begin
    res_next = conv_done_i ? conversion_result_i : res_reg;
    cw_next  = ctrl_commit ? avs_writedata_i[7:0] : cw_reg;
  end
  always_ff @(posedge ref_clk_i) begin
    res_reg <= res_next;
    cw_reg  <= cw_next;
  end

  // ----------
  // properties
  // ----------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i || por_rst_i);

  sequence s_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_load_rd(idx);
    conv_done_i ##1 (avs_read_i && avs_waitrequest_o && avs_address_i == idx);
  endsequence

  property p_wait_ack; s_take |=> !avs_waitrequest_o; endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("no ack after request");
  property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("ack longer than one cycle");
  property p_wait_idle;
    avs_waitrequest_o && !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("ack without request");
  property p_reset;
    disable iff (1'b0) (sys_rst_i || por_rst_i) |=> avs_waitrequest_o && avs_readdata_o == '0
      && {justify_select_o, previous_source_select_o, shift_count_o} == 5'h00
      && filter_mode_o == MD_BASIC && !lower_threshold_o && !upper_threshold_o;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_upper; avs_readdata_o[BUS_W-1:8] == '0; endproperty
  a_upper: assert property (p_upper) else $error("read data above byte not zero");
  property p_ctrl_wr;
    ctrl_commit |-> ##[1:2]
      {filter_mode_o, shift_count_o, previous_source_select_o, justify_select_o} == cw_reg;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control copy wrong");
  property p_ctrl_hold;
    $changed({filter_mode_o, shift_count_o, previous_source_select_o, justify_select_o})
      |-> $past(ctrl_commit) || $past(sys_rst_i) || $past(por_rst_i);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unasked");
  property p_res_hi;
    s_load_rd(5'h00) |=> avs_readdata_o[7:0] ==
      (justify_select_o ? {6'h00, res_reg[9:8]} : res_reg[9:2]);
  endproperty
  a_res_hi: assert property (p_res_hi) else $error("result high byte wrong");
  property p_res_lo;
    s_load_rd(5'h01) |=> avs_readdata_o[7:0] ==
      (justify_select_o ? res_reg[7:0] : {res_reg[1:0], 6'h00});
  endproperty
  a_res_lo: assert property (p_res_lo) else $error("result low byte wrong");
endmodule

bind adcrc_regs adcrc_regs_monitor #(.BUS_W(BUS_W)) u_mon (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .por_rst_i(por_rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .conv_done_i(conv_done_i), .conversion_result_i(conversion_result_i),
  .justify_select_o(justify_select_o), .previous_source_select_o(previous_source_select_o),
  .shift_count_o(shift_count_o), .filter_mode_o(filter_mode_o),
  .lower_threshold_o(lower_threshold_o), .upper_threshold_o(upper_threshold_o));

// File: bench/test_adc_result_computation_regs.sv
// test_adc_result_computation_regs: self-checking bench of the result bank.
// assumes adcrc_regs with default parameters and the bound monitor.
`timescale 1ns/1ns
module test_adc_result_computation_regs;
  import adcrc_pkg::*;
  typedef struct packed {logic j; logic [9:0] r; logic [7:0] hi; logic [7:0] lo;} adcrc_row_t;
  typedef struct packed {logic [7:0] m; logic [7:0] eh; logic [7:0] el; logic [7:0] st;} adcrc_crow_t;
  logic        ref_clk_i, sys_rst_i, por_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        conv_start_i, conv_done_i, acc_load_i, justify_select_o, previous_source_select_o;
  logic        lower_threshold_o, upper_threshold_o;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, d;
  logic [3:0]  avs_byteenable_i;
  logic [9:0]  conversion_result_i;
  logic [15:0] accumulator_value_i, lpf_output_i;
  logic [2:0]  shift_count_o;
  adcrc_mode_t filter_mode_o;
  int          errors, samples_checked, cycles;
  adcrc_row_t  rows [5] = '{'{1'b0, 10'h3ff, 8'hff, 8'hc0}, '{1'b0, 10'h2a5, 8'ha9, 8'h40},
                         '{1'b1, 10'h2a5, 8'h02, 8'ha5}, '{1'b1, 10'h17e, 8'h01, 8'h7e},
                         '{1'b0, 10'h001, 8'h00, 8'h40}};
  adcrc_crow_t crows [5] = '{'{8'h00, 8'h00, 8'hc0, 8'h02}, '{8'h01, 8'h00, 8'h9c, 8'h00},
                          '{8'h02, 8'hff, 8'hf2, 8'h01}, '{8'h03, 8'hff, 8'hce, 8'h01},
                          '{8'h04, 8'h00, 8'h00, 8'h00}};

  adcrc_regs dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .por_rst_i(por_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
    .conversion_result_i(conversion_result_i), .acc_load_i(acc_load_i),
    .accumulator_value_i(accumulator_value_i), .lpf_output_i(lpf_output_i),
    .justify_select_o(justify_select_o), .previous_source_select_o(previous_source_select_o),
    .shift_count_o(shift_count_o), .filter_mode_o(filter_mode_o),
    .lower_threshold_o(lower_threshold_o), .upper_threshold_o(upper_threshold_o));

  // ----------
  // clock and hang guard
  // ----------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  // ----------
  // tasks
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus_acc(input logic wr, input logic [4:0] idx, input logic [7:0] wd,
                         input logic [3:0] be, output logic [31:0] rd);
    avs_address_i <= idx;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= 32'(wd);
    avs_byteenable_i <= be;
    do @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] v);
    bus_acc(1'b1, idx, v, 4'h1, d);
  endtask
  task automatic rd_chk(input logic [4:0] idx, input logic [7:0] exp);
    bus_acc(1'b0, idx, 8'h00, 4'hf, d);
    check(d, 32'(exp));
  endtask
  // one-cycle converter strobe: bit0 done, bit1 start, bit2 accumulator load
  task automatic strobe(input logic [2:0] s, input logic [15:0] v);
    {acc_load_i, conv_start_i, conv_done_i} <= s;
    conversion_result_i <= v[9:0];
    accumulator_value_i <= v;
    @(posedge ref_clk_i);
    {acc_load_i, conv_start_i, conv_done_i} <= 3'b000;
  endtask
  task automatic pulse_rst(input logic por);
    {por_rst_i, sys_rst_i} <= {por, !por};
    repeat (2) @(posedge ref_clk_i);
    {por_rst_i, sys_rst_i} <= 2'b00;
    @(posedge ref_clk_i);
  endtask
  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------
  // main sequence
  // ----------
  initial begin
    {sys_rst_i, por_rst_i} = 2'b11;
    {avs_read_i, avs_write_i, conv_start_i, conv_done_i, acc_load_i} = 5'h00;
    {avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
    {conversion_result_i, accumulator_value_i, lpf_output_i} = '0;
    repeat (12) @(posedge ref_clk_i);
    {sys_rst_i, por_rst_i} <= 2'b00;
    @(posedge ref_clk_i);
    // justification table
    for (int i = 0; i < 5; i++) begin
      wr(5'h0a, {7'h00, rows[i].j});
      strobe(3'b001, {6'h00, rows[i].r});
      rd_chk(5'h00, rows[i].hi);
      strobe(3'b001, {6'h00, rows[i].r});
      rd_chk(5'h01, rows[i].lo);
    end
    // error arithmetic for every calc select, with threshold flags
    wr(5'h0a, 8'h21);
    strobe(3'b001, 16'h0040);
    wr(5'h06, 8'h00);
    strobe(3'b010, 16'h0000);
    wr(5'h07, 8'h64);
    strobe(3'b001, 16'h0100);
    wr(5'h0e, 8'h00);
    strobe(3'b100, 16'h0032);
    rd_chk(5'h03, 8'h40);
    rd_chk(5'h07, 8'h64);
    wr(5'h0f, 8'ha0);
    for (int i = 0; i < 5; i++) begin
      wr(5'h0b, crows[i].m);
      rd_chk(5'h08, crows[i].eh);
      rd_chk(5'h09, crows[i].el);
      rd_chk(5'h10, crows[i].st);
      check({30'h0, upper_threshold_o, lower_threshold_o}, {24'h0, crows[i].st});
    end
    // shifted accumulator in each averaging mode
    strobe(3'b100, 16'h8120);
    for (int m = 1; m < 4; m++) begin
      wr(5'h0a, 8'h09 | 8'(m << 5));
      rd_chk(5'h11, 8'he0);
      rd_chk(5'h12, 8'h48);
    end
    rd_chk(5'h04, 8'h81);
    rd_chk(5'h05, 8'h20);
    wr(5'h04, 8'h7f);
    rd_chk(5'h04, 8'h7f);
    // filter-sourced snapshot in low-pass mode
    wr(5'h0a, 8'h83);
    lpf_output_i <= 16'hbeef;
    repeat (2) @(posedge ref_clk_i);
    strobe(3'b010, 16'h0000);
    rd_chk(5'h02, 8'hbe);
    rd_chk(5'h03, 8'hef);
    rd_chk(5'h11, 8'hbe);
    // refused writes: read-only, lane off, unmapped; then an accepted result byte write
    wr(5'h02, 8'h55);
    rd_chk(5'h02, 8'hbe);
    bus_acc(1'b1, 5'h06, 8'hff, 4'h0, d);
    rd_chk(5'h06, 8'h00);
    wr(5'h1f, 8'h77);
    rd_chk(5'h1f, 8'h00);
    wr(5'h00, 8'h5a);
    rd_chk(5'h00, 8'h5a);
    // plain reset keeps result and accumulator, power-on clears them
    pulse_rst(1'b0);
    check({31'h0, justify_select_o}, 32'h0);
    rd_chk(5'h00, 8'h5a);
    rd_chk(5'h04, 8'h7f);
    rd_chk(5'h07, 8'h00);
    pulse_rst(1'b1);
    rd_chk(5'h00, 8'h00);
    rd_chk(5'h04, 8'h00);
    stop_test();
  end
endmodule

// File: core/adcrc_calc.sv
// adcrc_calc: filter output selection and calculation error arithmetic.
// assumes operands other than lpf_output_i are registered by the parent; purely combinational.
`timescale 1ns/1ns
module adcrc_calc (
  input  wire logic [15:0]          result_pair_i,
  input  wire logic [15:0]          previous_value_i,
  input  wire logic [15:0]          accumulator_value_i,
  input  wire logic [15:0]          threshold_setpoint_i,
  input  wire logic [15:0]          lpf_output_i,
  input  wire logic                 justify_select_i,
  input  wire logic                 previous_source_select_i,
  input  wire logic [2:0]           shift_count_i,
  input  wire adcrc_pkg::adcrc_mode_t filter_mode_i,
  input  wire adcrc_pkg::adcrc_calc_t calc_mode_select_i,
  output logic      [15:0]          filter_output_o,
  output logic      [15:0]          calculation_error_o
);
  import adcrc_pkg::*;

  logic signed [15:0] res_s;
  logic signed [15:0] prev_s;

  // ------------------------------------------------------------------
  // filter output and error
  // ------------------------------------------------------------------
  always_comb begin
    res_s = signed'({6'h00, adcrc_unjustify(result_pair_i, justify_select_i)});
    // prev holds filter scale when filter-sourced, justified result otherwise
    prev_s = previous_source_select_i ? signed'(previous_value_i)
           : signed'({6'h00, adcrc_unjustify(previous_value_i, justify_select_i)});
    case (filter_mode_i)
      MD_LPF:  filter_output_o = lpf_output_i;
      default: filter_output_o = 16'(signed'(accumulator_value_i) >>> shift_count_i);
    endcase
    case (calc_mode_select_i)
      CALC_RES_PREV: calculation_error_o = 16'(res_s - prev_s);
      CALC_RES_STPT: calculation_error_o = 16'(res_s - signed'(threshold_setpoint_i));
      CALC_FLT_PREV: calculation_error_o = 16'(signed'(filter_output_o) - prev_s);
      CALC_FLT_STPT: calculation_error_o = 16'(signed'(filter_output_o)
                                               - signed'(threshold_setpoint_i));
      default:       calculation_error_o = `ADCRC_WORD_RST;
    endcase
  end
endmodule

// File: core/adcrc_defines.svh
// adcrc_defines.svh: register indices, field positions and reset values
// of the converter result register bank; included by the bank's files.
`ifndef ADCRC_DEFINES_SVH
`define ADCRC_DEFINES_SVH

// ------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ------------------------------------------------------------------
`define ADCRC_IDX_RES_HI   5'h00
`define ADCRC_IDX_RES_LO   5'h01
`define ADCRC_IDX_PREV_HI  5'h02
`define ADCRC_IDX_PREV_LO  5'h03
`define ADCRC_IDX_ACC_HI   5'h04
`define ADCRC_IDX_ACC_LO   5'h05
`define ADCRC_IDX_STPT_HI  5'h06
`define ADCRC_IDX_STPT_LO  5'h07
`define ADCRC_IDX_ERR_HI   5'h08
`define ADCRC_IDX_ERR_LO   5'h09
`define ADCRC_IDX_CTRL     5'h0a
`define ADCRC_IDX_CALC     5'h0b
`define ADCRC_IDX_LTH_HI   5'h0c
`define ADCRC_IDX_LTH_LO   5'h0d
`define ADCRC_IDX_UTH_HI   5'h0e
`define ADCRC_IDX_UTH_LO   5'h0f
`define ADCRC_IDX_STAT     5'h10
`define ADCRC_IDX_FLT_HI   5'h11
`define ADCRC_IDX_FLT_LO   5'h12

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define ADCRC_CTRL_JUST    0
`define ADCRC_CTRL_PSS     1
`define ADCRC_CTRL_SHF_LO  2
`define ADCRC_CTRL_SHF_HI  4
`define ADCRC_CTRL_MD_LO   5
`define ADCRC_CTRL_MD_HI   7
`define ADCRC_CALC_LO      0
`define ADCRC_CALC_HI      2
`define ADCRC_STAT_LTH     0
`define ADCRC_STAT_UTH     1

// ------------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------------
`define ADCRC_LANE0        0
`define ADCRC_BYTE_RST     8'h00
`define ADCRC_WORD_RST     16'h0000
`define ADCRC_RD_RST       32'h0000_0000
`define ADCRC_JUST_PAD     6'h00

`endif

// File: core/adcrc_pkg.sv
// adcrc_pkg: types and justification helpers of the result bank.
// assumes adcrc_defines.svh sits on the include path.
package adcrc_pkg;
  `include "adcrc_defines.svh"

  // filter engine modes, set by software in the control register
  typedef enum logic [2:0] {MD_BASIC, MD_ACCUM, MD_AVERAGE, MD_BURST, MD_LPF} adcrc_mode_t;

  // error arithmetic choices for the calc select field
  typedef enum logic [2:0] {CALC_RES_PREV, CALC_RES_STPT, CALC_FLT_PREV, CALC_FLT_STPT}
    adcrc_calc_t;

  // bus handshake states
  typedef enum logic {ST_IDLE, ST_ACK} adcrc_bus_t;

  // place a 10-bit result into the high/low byte pair
  function automatic logic [15:0] adcrc_justify(input logic [9:0] res, input logic right);
    adcrc_justify = right ? {`ADCRC_JUST_PAD, res} : {res, `ADCRC_JUST_PAD};
  endfunction

  // recover the 10-bit result from a justified byte pair
  function automatic logic [9:0] adcrc_unjustify(input logic [15:0] pair, input logic right);
    adcrc_unjustify = right ? pair[9:0] : pair[15:6];
  endfunction
endpackage

// File: core/adcrc_regs.sv
// adcrc_regs: software register bank of the converter result and
// computation extension, reached over an avalon-mm slave port.
// assumes conversion sequencing, accumulation and low-pass arithmetic
// live outside and deliver one-cycle strobes on ref_clk_i.
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns

// Operation
// - left format: result bits 9..2 fill the high result byte.
// - left format: result bits 1..0 in low byte bits 7..6, rest zero.
// - right format: result bits 9..8 in high byte bits 1..0, rest zero.
// - right format: result bits 7..0 fill the low result byte.
// - filter-sourced: conversion start copies the 16-bit filter output to previous.
// - result-sourced: conversion start copies the justified result to previous.
// - 16-bit signed accumulator, two writable bytes, sign in high byte.
// - writable 16-bit setpoint, an operand only for setpoint calc modes.
// - read-only 16-bit calculation error, arithmetic chosen by calc select.
// - filter output is accumulator shifted right, or low-pass output.
// - error compared with lower and upper thresholds sets status flags.
module adcrc_regs #(
  parameter int ADC_BITS = 10,
  parameter int BUS_W    = 32
) (
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                por_rst_i,
  input  wire logic [4:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [BUS_W-1:0]    avs_writedata_i,
  input  wire logic [BUS_W/8-1:0]  avs_byteenable_i,
  output logic      [BUS_W-1:0]    avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic                conv_start_i,
  input  wire logic                conv_done_i,
  input  wire logic [9:0]          conversion_result_i,
  input  wire logic                acc_load_i,
  input  wire logic [15:0]         accumulator_value_i,
  input  wire logic [15:0]         lpf_output_i,
  output logic                     justify_select_o,
  output logic                     previous_source_select_o,
  output logic      [2:0]          shift_count_o,
  output adcrc_pkg::adcrc_mode_t   filter_mode_o,
  output logic                     lower_threshold_o,
  output logic                     upper_threshold_o
);
  import adcrc_pkg::*;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (ADC_BITS != 10) begin : g_bits_chk
    $error("adcrc_regs serves a 10-bit converter only");
  end
  if (BUS_W != 32) begin : g_bus_chk
    $error("adcrc_regs needs a 32-bit avalon data bus");
  end

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  adcrc_bus_t         bus_reg,   bus_next;
  logic               wait_reg,  wait_next;
  logic [BUS_W-1:0]   rd_reg,    rd_next;
  logic [7:0]         res_hi_reg, res_hi_next;
  logic [7:0]         res_lo_reg, res_lo_next;
  logic [15:0]        acc_reg,   acc_next;
  logic [15:0]        prev_reg,  prev_next;
  logic [15:0]        stpt_reg,  stpt_next;
  logic [15:0]        lth_reg,   lth_next;
  logic [15:0]        uth_reg,   uth_next;
  logic [7:0]         ctrl_reg,  ctrl_next;
  logic [2:0]         calc_reg,  calc_next;
  logic [15:0]        flt_reg,   flt_next;
  logic [15:0]        err_reg,   err_next;
  logic               lth_flag_reg, lth_flag_next;
  logic               uth_flag_reg, uth_flag_next;
  logic               wr_go;
  logic [7:0]         wr_byte;
  logic [15:0]        flt_comb;
  logic [15:0]        err_comb;
  logic [15:0]        just_res;

  // byte write of one register index on the committing edge
  function automatic logic hit(input logic [4:0] idx, input logic [4:0] adr, input logic go);
    hit = go && (adr == idx);
  endfunction

  // ------------------------------------------------------------------
  // avalon handshake
  // ------------------------------------------------------------------
  // waitrequest drops for one cycle, one cycle after the request is sampled
  assign wr_go   = (bus_reg == ST_ACK) && avs_write_i
                   && avs_byteenable_i[`ADCRC_LANE0];
  assign wr_byte = avs_writedata_i[7:0];

  // next bus state and read data capture
  always_comb begin
    bus_next  = bus_reg;
    wait_next = 1'b1;
    rd_next   = rd_reg;
    case (bus_reg)
      ST_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          bus_next  = ST_ACK;
          wait_next = 1'b0;
          rd_next   = `ADCRC_RD_RST;
          case (avs_address_i)
            `ADCRC_IDX_RES_HI:  rd_next[7:0] = res_hi_reg;
            `ADCRC_IDX_RES_LO:  rd_next[7:0] = res_lo_reg;
            `ADCRC_IDX_PREV_HI: rd_next[7:0] = prev_reg[15:8];
            `ADCRC_IDX_PREV_LO: rd_next[7:0] = prev_reg[7:0];
            `ADCRC_IDX_ACC_HI:  rd_next[7:0] = acc_reg[15:8];
            `ADCRC_IDX_ACC_LO:  rd_next[7:0] = acc_reg[7:0];
            `ADCRC_IDX_STPT_HI: rd_next[7:0] = stpt_reg[15:8];
            `ADCRC_IDX_STPT_LO: rd_next[7:0] = stpt_reg[7:0];
            `ADCRC_IDX_ERR_HI:  rd_next[7:0] = err_reg[15:8];
            `ADCRC_IDX_ERR_LO:  rd_next[7:0] = err_reg[7:0];
            `ADCRC_IDX_CTRL:    rd_next[7:0] = ctrl_reg;
            `ADCRC_IDX_CALC:    rd_next[2:0] = calc_reg;
            `ADCRC_IDX_LTH_HI:  rd_next[7:0] = lth_reg[15:8];
            `ADCRC_IDX_LTH_LO:  rd_next[7:0] = lth_reg[7:0];
            `ADCRC_IDX_UTH_HI:  rd_next[7:0] = uth_reg[15:8];
            `ADCRC_IDX_UTH_LO:  rd_next[7:0] = uth_reg[7:0];
            `ADCRC_IDX_STAT:    rd_next[1:0] = {uth_flag_reg, lth_flag_reg};
            `ADCRC_IDX_FLT_HI:  rd_next[7:0] = flt_reg[15:8];
            `ADCRC_IDX_FLT_LO:  rd_next[7:0] = flt_reg[7:0];
            default:            rd_next      = `ADCRC_RD_RST;
          endcase
        end
      end
      ST_ACK: begin
        bus_next = ST_IDLE;
      end
      default: begin
        bus_next = ST_IDLE;
      end
    endcase
  end

  // bus state registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || por_rst_i) begin
      bus_reg  <= ST_IDLE;
      wait_reg <= 1'b1;
      rd_reg   <= `ADCRC_RD_RST;
    end else begin
      bus_reg  <= bus_next;
      wait_reg <= wait_next;
      rd_reg   <= rd_next;
    end
  end

  // ------------------------------------------------------------------
  // control, setpoint and threshold registers
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    calc_next = calc_reg;
    stpt_next = stpt_reg;
    lth_next  = lth_reg;
    uth_next  = uth_reg;
    if (hit(`ADCRC_IDX_CTRL, avs_address_i, wr_go)) begin
      ctrl_next = wr_byte;
    end
    if (hit(`ADCRC_IDX_CALC, avs_address_i, wr_go)) begin
      calc_next = wr_byte[`ADCRC_CALC_HI:`ADCRC_CALC_LO];
    end
    if (hit(`ADCRC_IDX_STPT_HI, avs_address_i, wr_go)) begin
      stpt_next[15:8] = wr_byte;
    end
    if (hit(`ADCRC_IDX_STPT_LO, avs_address_i, wr_go)) begin
      stpt_next[7:0] = wr_byte;
    end
    if (hit(`ADCRC_IDX_LTH_HI, avs_address_i, wr_go)) begin
      lth_next[15:8] = wr_byte;
    end
    if (hit(`ADCRC_IDX_LTH_LO, avs_address_i, wr_go)) begin
      lth_next[7:0] = wr_byte;
    end
    if (hit(`ADCRC_IDX_UTH_HI, avs_address_i, wr_go)) begin
      uth_next[15:8] = wr_byte;
    end
    if (hit(`ADCRC_IDX_UTH_LO, avs_address_i, wr_go)) begin
      uth_next[7:0] = wr_byte;
    end
  end

  // control state clears on every reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || por_rst_i) begin
      ctrl_reg <= `ADCRC_BYTE_RST;
      calc_reg <= 3'h0;
      stpt_reg <= `ADCRC_WORD_RST;
      lth_reg  <= `ADCRC_WORD_RST;
      uth_reg  <= `ADCRC_WORD_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      calc_reg <= calc_next;
      stpt_reg <= stpt_next;
      lth_reg  <= lth_next;
      uth_reg  <= uth_next;
    end
  end

  // ------------------------------------------------------------------
  // result, accumulator and previous-value registers
  // ------------------------------------------------------------------
  // justify new result
  assign just_res = adcrc_justify(conversion_result_i, ctrl_reg[`ADCRC_CTRL_JUST]);

  always_comb begin
    res_hi_next = res_hi_reg;
    res_lo_next = res_lo_reg;
    acc_next    = acc_reg;
    prev_next   = prev_reg;
    // software writes, overridden by hardware in the same cycle
    if (hit(`ADCRC_IDX_RES_HI, avs_address_i, wr_go)) begin
      res_hi_next = wr_byte;
    end
    if (hit(`ADCRC_IDX_RES_LO, avs_address_i, wr_go)) begin
      res_lo_next = wr_byte;
    end
    if (hit(`ADCRC_IDX_ACC_HI, avs_address_i, wr_go)) begin
      acc_next[15:8] = wr_byte;
    end
    if (hit(`ADCRC_IDX_ACC_LO, avs_address_i, wr_go)) begin
      acc_next[7:0] = wr_byte;
    end
    if (acc_load_i) begin
      acc_next = accumulator_value_i;
    end
    if (conv_done_i) begin
      res_hi_next = just_res[15:8];
      res_lo_next = just_res[7:0];
    end
    if (conv_start_i) begin
      prev_next = ctrl_reg[`ADCRC_CTRL_PSS] ? flt_reg : {res_hi_reg, res_lo_reg};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (por_rst_i) begin
      res_hi_reg <= `ADCRC_BYTE_RST;
      res_lo_reg <= `ADCRC_BYTE_RST;
      acc_reg    <= `ADCRC_WORD_RST;
      prev_reg   <= `ADCRC_WORD_RST;
    end else begin
      res_hi_reg <= res_hi_next;
      res_lo_reg <= res_lo_next;
      acc_reg    <= acc_next;
      prev_reg   <= prev_next;
    end
  end

  // ------------------------------------------------------------------
  // computation: filter, error and threshold status
  // ------------------------------------------------------------------
  adcrc_calc u_calc (
    .result_pair_i            ({res_hi_reg, res_lo_reg}),
    .previous_value_i         (prev_reg),
    .accumulator_value_i      (acc_reg),
    .threshold_setpoint_i     (stpt_reg),
    .lpf_output_i             (lpf_output_i),
    .justify_select_i         (ctrl_reg[`ADCRC_CTRL_JUST]),
    .previous_source_select_i (ctrl_reg[`ADCRC_CTRL_PSS]),
    .shift_count_i            (ctrl_reg[`ADCRC_CTRL_SHF_HI:`ADCRC_CTRL_SHF_LO]),
    .filter_mode_i            (adcrc_mode_t'(ctrl_reg[`ADCRC_CTRL_MD_HI:`ADCRC_CTRL_MD_LO])),
    .calc_mode_select_i       (adcrc_calc_t'(calc_reg)),
    .filter_output_o          (flt_comb),
    .calculation_error_o      (err_comb)
  );

  always_comb begin
    flt_next      = flt_comb;
    err_next      = err_comb;
    lth_flag_next = signed'(err_reg) < signed'(lth_reg);
    uth_flag_next = signed'(err_reg) > signed'(uth_reg);
  end

  // computed values track their operands one cycle late
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || por_rst_i) begin
      flt_reg      <= `ADCRC_WORD_RST;
      err_reg      <= `ADCRC_WORD_RST;
      lth_flag_reg <= 1'b0;
      uth_flag_reg <= 1'b0;
    end else begin
      flt_reg      <= flt_next;
      err_reg      <= err_next;
      lth_flag_reg <= lth_flag_next;
      uth_flag_reg <= uth_flag_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ------------------------------------------------------------------
  assign avs_readdata_o           = rd_reg;
  assign avs_waitrequest_o        = wait_reg;
  assign justify_select_o         = ctrl_reg[`ADCRC_CTRL_JUST];
  assign previous_source_select_o = ctrl_reg[`ADCRC_CTRL_PSS];
  assign shift_count_o            = ctrl_reg[`ADCRC_CTRL_SHF_HI:`ADCRC_CTRL_SHF_LO];
  assign filter_mode_o            = adcrc_mode_t'(ctrl_reg[`ADCRC_CTRL_MD_HI:`ADCRC_CTRL_MD_LO]);
  assign lower_threshold_o        = lth_flag_reg;
  assign upper_threshold_o        = uth_flag_reg;
endmodule
